// file: rtl/asr_pkg.sv
package asr_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADR_W  = 5;
    localparam int DAT_W  = 32;
    localparam int SEL_W  = 4;
    localparam int CTRL_W = 16;
    localparam int EV_W   = 5;
    localparam int STAT_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFS_CTRL     = 5'h00;
    localparam logic [ADR_W-1:0] OFS_STATUS   = 5'h04;
    localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 5'h08;
    localparam logic [ADR_W-1:0] OFS_IRQ_CLR  = 5'h0C;
    localparam logic [ADR_W-1:0] OFS_IRQ_EN   = 5'h10;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ALLOW = 0;   // 1: remote control allowed
    localparam int CTRL_RMODE = 1;   // resistance regulation enable
    localparam int CTRL_SPEED = 2;   // 2-bit controller speed
    localparam int CTRL_RANGE = 4;   // 1: 10 V analog range
    localparam int CTRL_SBINV = 5;   // standby pin inverted
    localparam int CTRL_SBACT = 6;   // 1: standby pin may switch on again
    localparam int CTRL_PIN6  = 7;   // 2-bit first alarm source
    localparam int CTRL_PIN14 = 9;   // 3-bit second alarm mask
    localparam int CTRL_PIN15 = 12;  // 1: third pin shows DC state

    // mask bits inside the second alarm field
    localparam int P14_OV = 0;
    localparam int P14_OC = 1;
    localparam int P14_OP = 2;

    typedef enum logic [1:0] {
        ASR_SPD_SLOW   = 2'b00,
        ASR_SPD_NORMAL = 2'b01,
        ASR_SPD_FAST   = 2'b10
    } asr_speed_type;

    typedef enum logic [1:0] {
        ASR_P6_OT   = 2'b00,
        ASR_P6_PF   = 2'b01,
        ASR_P6_BOTH = 2'b10
    } asr_pin6_type;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0]        PIN14_RST  = 3'h1;
    localparam logic [CTRL_W-1:0] CTRL_RST   = CTRL_W'(1 << CTRL_ALLOW)
                                             | CTRL_W'({14'h0000, ASR_SPD_NORMAL} << CTRL_SPEED)
                                             | CTRL_W'({14'h0000, ASR_P6_BOTH} << CTRL_PIN6)
                                             | CTRL_W'({13'h0000, PIN14_RST} << CTRL_PIN14);
    localparam logic [EV_W-1:0]   IRQ_EN_RST = 5'h00;

    // ------------------------------------------------------------
    // event and status bits
    // ------------------------------------------------------------
    localparam int EV_PF      = 0;
    localparam int EV_OT      = 1;
    localparam int EV_P14     = 2;
    localparam int EV_SB_OFF  = 3;
    localparam int EV_REFUSED = 4;

    localparam int ST_DC     = 0;
    localparam int ST_MENU   = 1;
    localparam int ST_LOCAL  = 2;
    localparam int ST_SB     = 3;
    localparam int ST_PIN6   = 4;
    localparam int ST_PIN14  = 5;
    localparam int ST_PIN15  = 6;
    localparam int ST_RESUME = 7;

endpackage : asr_pkg

// file: rtl/asr_wb_slave.sv
`timescale 1ns/100ps
module asr_wb_slave (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [asr_pkg::DAT_W-1:0]  rd_data_i,
    output logic                            ack_o,
    output logic      [asr_pkg::DAT_W-1:0]  dat_o,
    output logic                            wr_o
);
    import asr_pkg::*;

    typedef struct packed {
        logic             ack;
        logic [DAT_W-1:0] dat;
    } asr_wb_state_type;

    asr_wb_state_type s;
    asr_wb_state_type next_s;

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    // ack one cycle after the request, read data captured with it
    always_comb begin
        next_s = s;
        if (cyc_i && stb_i && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.dat = rd_data_i;
        end else begin
            next_s.ack = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // write lands on the edge where the master sees ack
    assign wr_o  = cyc_i & stb_i & we_i & s.ack & ce_i;
    assign ack_o = s.ack;
    assign dat_o = s.dat;

endmodule : asr_wb_slave

// file: rtl/asr_irq.sv
`timescale 1ns/100ps
module asr_irq (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      ce_i,
    input  wire logic [asr_pkg::EV_W-1:0]  ev_i,
    input  wire logic                      clr_wr_i,
    input  wire logic                      en_wr_i,
    input  wire logic [asr_pkg::EV_W-1:0]  wdata_i,
    output logic      [asr_pkg::EV_W-1:0]  stat_o,
    output logic      [asr_pkg::EV_W-1:0]  en_o,
    output logic                           irq_o
);
    import asr_pkg::*;

    typedef struct packed {
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] en;
        logic            irq;
    } asr_irq_state_type;

    asr_irq_state_type s;
    asr_irq_state_type next_s;
    logic [EV_W-1:0]   stat_nx;

    // ------------------------------------------------------------
    // sticky bits
    // ------------------------------------------------------------
    // a new event beats a clear in the same cycle
    for (genvar g = 0; g < EV_W; g++) begin : g_bit
        assign stat_nx[g] = ev_i[g] | (s.stat[g] & ~(clr_wr_i & wdata_i[g]));
    end

    always_comb begin
        next_s      = s;
        next_s.stat = stat_nx;
        if (en_wr_i) begin
            next_s.en = wdata_i;
        end
        next_s.irq = |(stat_nx & next_s.en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s     <= '0;
            s.en  <= IRQ_EN_RST;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign stat_o = s.stat;
    assign en_o   = s.en;
    assign irq_o  = s.irq;

endmodule : asr_irq

// file: rtl/asr_router.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module asr_router (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [asr_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [asr_pkg::SEL_W-1:0]  wb_sel_i,
    input  wire logic [asr_pkg::DAT_W-1:0]  wb_dat_i,
    output logic      [asr_pkg::DAT_W-1:0]  wb_dat_o,
    output logic                            wb_ack_o,
    output logic                            irq_o,
    input  wire logic                       overtemp_alarm_i,
    input  wire logic                       power_fail_alarm_i,
    input  wire logic                       overvoltage_alarm_i,
    input  wire logic                       overcurrent_alarm_i,
    input  wire logic                       overpower_alarm_i,
    input  wire logic                       const_voltage_regulation_i,
    input  wire logic                       remote_standby_input_i,
    input  wire logic                       analog_remote_i,
    input  wire logic                       local_on_i,
    input  wire logic                       local_off_i,
    input  wire logic                       remote_on_i,
    input  wire logic                       remote_off_i,
    input  wire logic                       menu_touch_i,
    input  wire logic                       menu_exit_i,
    output logic                            alarm_pin6_o,
    output logic                            alarm_pin14_o,
    output logic                            status_pin15_o,
    output logic                            dc_on_o,
    output logic                            menu_shown_o,
    output logic                            status_view_o,
    output logic                            local_only_o,
    output logic                            r_mode_o,
    output logic                            show_resistance_o,
    output logic      [1:0]                 vctl_speed_o,
    output logic                            ref_10v_o
);
    import asr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic              sb_meta;
        logic              sb_sync;
        logic              dc_on;
        logic              resume;
        logic              pin6;
        logic              pin14;
        logic              pin15;
        logic              menu;
        logic              status_view;
        logic              local_only;
        logic              r_mode;
        logic              show_res;
        logic [1:0]        speed;
        logic              ref_10v;
        logic              prev_pf;
        logic              prev_ot;
    } asr_main_state_type;

    asr_main_state_type s;
    asr_main_state_type next_s;

    logic               bus_wr;
    logic [DAT_W-1:0]   rd_data;
    logic [EV_W-1:0]    events;
    logic [EV_W-1:0]    irq_stat;
    logic [EV_W-1:0]    irq_en;
    logic [ADR_W-1:0]   wofs;
    logic [CTRL_W-1:0]  ctrl_wr;
    logic               allow;
    logic               sb_eff;
    logic               analog_mode;
    logic               sb_onoff;
    logic [2:0]         p14_mask;
    logic [1:0]         p6_sel;
    logic [1:0]         spd_sel;

    // ------------------------------------------------------------
    // bus slave and interrupt block
    // ------------------------------------------------------------
    asr_wb_slave u_wb (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .cyc_i     (wb_cyc_i),
        .stb_i     (wb_stb_i),
        .we_i      (wb_we_i),
        .rd_data_i (rd_data),
        .ack_o     (wb_ack_o),
        .dat_o     (wb_dat_o),
        .wr_o      (bus_wr)
    );

    asr_irq u_irq (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .ev_i     (events),
        .clr_wr_i (bus_wr && wofs == OFS_IRQ_CLR && wb_sel_i[0]),
        .en_wr_i  (bus_wr && wofs == OFS_IRQ_EN && wb_sel_i[0]),
        .wdata_i  (wb_dat_i[EV_W-1:0]),
        .stat_o   (irq_stat),
        .en_o     (irq_en),
        .irq_o    (irq_o)
    );

    // word-aligned offset; low address bits are ignored
    assign wofs = {wb_adr_i[ADR_W-1:2], 2'b00};

    // ------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------
    assign allow       = s.ctrl[CTRL_ALLOW];
    assign sb_onoff    = s.ctrl[CTRL_SBACT];
    assign p14_mask    = s.ctrl[CTRL_PIN14 +: 3];
    assign p6_sel      = s.ctrl[CTRL_PIN6 +: 2];
    assign spd_sel     = s.ctrl[CTRL_SPEED +: 2];
    assign sb_eff      = s.sb_sync ^ s.ctrl[CTRL_SBINV];
    assign analog_mode = analog_remote_i & allow;

    // byte-lane merge; an empty second-alarm mask is refused
    always_comb begin
        ctrl_wr = s.ctrl;
        if (wb_sel_i[0]) begin
            ctrl_wr[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            ctrl_wr[15:8] = wb_dat_i[15:8];
        end
        if (ctrl_wr[CTRL_PIN14 +: 3] == 3'h0) begin
            ctrl_wr[CTRL_PIN14 +: 3] = s.ctrl[CTRL_PIN14 +: 3];
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_data = '0;
        case (wofs)
            OFS_CTRL: begin
                rd_data[CTRL_W-1:0] = s.ctrl;
            end
            OFS_STATUS: begin
                rd_data[ST_DC]     = s.dc_on;
                rd_data[ST_MENU]   = s.menu;
                rd_data[ST_LOCAL]  = s.local_only;
                rd_data[ST_SB]     = sb_eff;
                rd_data[ST_PIN6]   = s.pin6;
                rd_data[ST_PIN14]  = s.pin14;
                rd_data[ST_PIN15]  = s.pin15;
                rd_data[ST_RESUME] = s.resume;
            end
            OFS_IRQ_STAT: begin
                rd_data[EV_W-1:0] = irq_stat;
            end
            OFS_IRQ_EN: begin
                rd_data[EV_W-1:0] = irq_en;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s         = s;
        events         = '0;
        next_s.sb_meta = remote_standby_input_i;
        next_s.sb_sync = s.sb_meta;
        next_s.prev_pf = power_fail_alarm_i;
        next_s.prev_ot = overtemp_alarm_i;
        if (bus_wr && wofs == OFS_CTRL) begin
            next_s.ctrl = ctrl_wr;
        end

        // DC stage: power fail first, then standby, then commands
        if (power_fail_alarm_i) begin
            next_s.dc_on  = 1'b0;
            next_s.resume = 1'b0;
        end else if (analog_mode) begin
            next_s.dc_on  = ~sb_eff;
            next_s.resume = 1'b0;
        end else if (sb_eff) begin
            // standby only ever cuts the stage here
            if (s.dc_on) begin
                events[EV_SB_OFF] = 1'b1;
                next_s.resume     = sb_onoff;
            end
            next_s.dc_on = 1'b0;
        end else if (s.resume && sb_onoff) begin
            next_s.dc_on  = 1'b1;
            next_s.resume = 1'b0;
        end else begin
            next_s.resume = 1'b0;
            if (local_off_i || (remote_off_i && allow)) begin
                next_s.dc_on = 1'b0;
            end else if (local_on_i || (remote_on_i && allow)) begin
                next_s.dc_on = 1'b1;
            end
        end
        // remote attempts under lockout are dropped and flagged
        events[EV_REFUSED] = ~allow & (remote_on_i | remote_off_i | analog_remote_i);

        // menu only with the stage off; status view otherwise
        if (next_s.dc_on || menu_exit_i) begin
            next_s.menu = 1'b0;
        end else if (menu_touch_i) begin
            next_s.menu = 1'b1;
        end
        next_s.status_view = next_s.dc_on;
        next_s.local_only  = ~allow;

        // alarm routing, one clock from inputs and selection
        unique case (p6_sel)
            ASR_P6_OT: begin
                next_s.pin6 = overtemp_alarm_i;
            end
            ASR_P6_PF: begin
                next_s.pin6 = power_fail_alarm_i;
            end
            default: begin
                next_s.pin6 = overtemp_alarm_i | power_fail_alarm_i;
            end
        endcase
        next_s.pin14 = (p14_mask[P14_OV] & overvoltage_alarm_i)
                     | (p14_mask[P14_OC] & overcurrent_alarm_i)
                     | (p14_mask[P14_OP] & overpower_alarm_i);
        next_s.pin15 = s.ctrl[CTRL_PIN15] ? s.dc_on : const_voltage_regulation_i;
        events[EV_PF]  = power_fail_alarm_i & ~s.prev_pf;
        events[EV_OT]  = overtemp_alarm_i & ~s.prev_ot;
        events[EV_P14] = next_s.pin14 & ~s.pin14;

        // settings driven out
        next_s.r_mode   = s.ctrl[CTRL_RMODE];
        next_s.show_res = s.ctrl[CTRL_RMODE];
        next_s.ref_10v  = s.ctrl[CTRL_RANGE];
        // the unused speed code runs at normal speed
        unique case (spd_sel)
            ASR_SPD_SLOW: begin
                next_s.speed = ASR_SPD_SLOW;
            end
            ASR_SPD_FAST: begin
                next_s.speed = ASR_SPD_FAST;
            end
            default: begin
                next_s.speed = ASR_SPD_NORMAL;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s        <= '0;
            s.ctrl   <= CTRL_RST;
            s.speed  <= ASR_SPD_NORMAL;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign alarm_pin6_o      = s.pin6;
    assign alarm_pin14_o     = s.pin14;
    assign status_pin15_o    = s.pin15;
    assign dc_on_o           = s.dc_on;
    assign menu_shown_o      = s.menu;
    assign status_view_o     = s.status_view;
    assign local_only_o      = s.local_only;
    assign r_mode_o          = s.r_mode;
    assign show_resistance_o = s.show_res;
    assign vctl_speed_o      = s.speed;
    assign ref_10v_o         = s.ref_10v;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    menu_off_only_a: assert property (menu_shown_o |-> !dc_on_o && !status_view_o)
        else $error("menu shown while DC output is on");
    lockout_hold_a: assert property (ce_i && !allow && !dc_on_o && !local_on_i && !s.resume |=> !dc_on_o)
        else $error("DC output switched on by remote under lockout");
    pin6_route_a: assert property (ce_i |=> alarm_pin6_o == ($past(p6_sel) == ASR_P6_OT ? $past(overtemp_alarm_i)
        : $past(p6_sel) == ASR_P6_PF ? $past(power_fail_alarm_i)
        : ($past(overtemp_alarm_i) | $past(power_fail_alarm_i))))
        else $error("first alarm pin does not follow its selection");
    pin14_route_a: assert property (ce_i |=> alarm_pin14_o == |($past(p14_mask)
        & {$past(overpower_alarm_i), $past(overcurrent_alarm_i), $past(overvoltage_alarm_i)}))
        else $error("second alarm pin does not follow its mask");
    pin14_mask_a: assert property (p14_mask != 3'h0)
        else $error("second alarm mask became empty");
    pin15_route_a: assert property (ce_i && !s.ctrl[CTRL_PIN15] |=> status_pin15_o == $past(const_voltage_regulation_i))
        else $error("third pin does not show regulation mode");
    sb_polarity_a: assert property ($past(ce_i) && $past(ce_i, 2) && $stable(s.ctrl[CTRL_SBINV])
        |-> sb_eff == ($past(remote_standby_input_i, 2) ^ s.ctrl[CTRL_SBINV]))
        else $error("standby level not synchronised with its polarity");
    sb_never_on_a: assert property (ce_i && sb_eff && !analog_mode ##1 ce_i && sb_eff && !analog_mode |=> !dc_on_o)
        else $error("standby input left the stage on");
    sb_resume_a: assert property (ce_i && s.resume && !sb_eff && sb_onoff && !analog_mode
        && !power_fail_alarm_i |=> dc_on_o && !s.resume)
        else $error("stage not restored after standby release");
    pf_off_a: assert property (ce_i && power_fail_alarm_i |=> !dc_on_o)
        else $error("power fail left the stage on");
    range_ref_a: assert property (ce_i |=> ref_10v_o == $past(s.ctrl[CTRL_RANGE]) && r_mode_o == $past(s.ctrl[CTRL_RMODE]))
        else $error("range or resistance mode output lags its setting");
    speed_legal_a: assert property (vctl_speed_o != 2'b11)
        else $error("illegal controller speed driven");

    cover_menu_c:    cover property (menu_touch_i && !dc_on_o ##1 menu_shown_o);
    cover_resume_c:  cover property (s.resume ##[1:20] dc_on_o);
    cover_refused_c: cover property (!allow && remote_on_i);
    cover_pin14_c:   cover property (alarm_pin14_o && p14_mask == 3'h7);

endmodule : asr_router

// file: verification/asr_ext_ctrl.sv
`timescale 1ns/100ps
// ----------------------------------------
// external controller on the analog connector
// ----------------------------------------
module asr_ext_ctrl (
    input  wire logic clk_i,
    input  wire logic standby_req_i,
    input  wire logic inverted_i,
    output logic      pin_o
);
    // pin level as wired; inverted wiring flips the level, not the request
    always_ff @(posedge clk_i) begin
        pin_o <= standby_req_i ^ inverted_i;
    end
endmodule : asr_ext_ctrl

// file: verification/asr_router_tb.sv
`timescale 1ns/100ps
module asr_router_tb;
    import asr_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic        ack, irq, ot = 1'h0, pf = 1'h0, ov = 1'h0, oc = 1'h0, op = 1'h0, cv = 1'h0;
    logic        sbq = 1'h0, inv = 1'h0, ana = 1'h0, pin, p6, p14, p15, dc, menu, sview, lonly, rmode, shr, r10;
    logic [5:0]  cmd = 6'h00;
    logic [1:0]  spd;
    int          n_mismatch = 0, checked = 0;

    asr_router DUT (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .overtemp_alarm_i(ot),
        .power_fail_alarm_i(pf), .overvoltage_alarm_i(ov), .overcurrent_alarm_i(oc), .overpower_alarm_i(op),
        .const_voltage_regulation_i(cv), .remote_standby_input_i(pin), .analog_remote_i(ana),
        .local_on_i(cmd[0]), .local_off_i(cmd[1]), .remote_on_i(cmd[2]), .remote_off_i(cmd[4]),
        .menu_touch_i(cmd[3]), .menu_exit_i(cmd[5]), .alarm_pin6_o(p6), .alarm_pin14_o(p14),
        .status_pin15_o(p15), .dc_on_o(dc), .menu_shown_o(menu), .status_view_o(sview), .local_only_o(lonly),
        .r_mode_o(rmode), .show_resistance_o(shr), .vctl_speed_o(spd), .ref_10v_o(r10));
    asr_ext_ctrl PEER (.clk_i(clk_i), .standby_req_i(sbq), .inverted_i(inv), .pin_o(pin));

    // 40 MHz system clock
    always #12.5 clk_i = ~clk_i;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one classic cycle; starts one edge later so a release never meets a new request
    // no cycle count is assumed: only the watchdog ends a wait for ack
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'h1);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
    endtask : bus
    // one-cycle command: 0 local on, 1 local off, 2 remote on, 3 menu touch, 4 remote off, 5 menu exit
    task automatic pulse(input int w);
        @(posedge clk_i);
        cmd <= 6'(1 << w);
        @(posedge clk_i);
        cmd <= 6'h00;
    endtask : pulse
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        tick(8);
        rst_i <= 1'h0;
        tick(1);
        bus(1'h0, OFS_CTRL, 32'h0);
        chk(q, 32'h305);
        chk(32'({spd, lonly}), 32'h2);
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 4; j++) begin
                bus(1'h1, OFS_CTRL, 32'h205 | (32'(i) << 7));
                {pf, ot} <= 2'(j);
                tick(3);
                chk(32'(p6), 32'(i == 0 ? j[0] : i == 1 ? j[1] : j != 0));
            end
        end
        {pf, ot} <= 2'h0;
        for (int m = 1; m < 8; m++) begin
            for (int k = 0; k < 3; k++) begin
                bus(1'h1, OFS_CTRL, 32'h105 | (32'(m) << 9));
                {op, oc, ov} <= 3'(1 << k);
                tick(3);
                chk(32'(p14), 32'(m[k]));
            end
        end
        {op, oc, ov} <= 3'h0;
        cv <= 1'h1;
        bus(1'h1, OFS_CTRL, 32'h305);
        tick(3);
        chk(32'(p15), 32'h1);
        bus(1'h1, OFS_CTRL, 32'h1305);
        tick(3);
        chk(32'(p15), 32'h0);
        pulse(3);
        tick(2);
        chk(32'(menu), 32'h1);
        pulse(5);
        tick(2);
        chk(32'(menu), 32'h0);
        pulse(3);
        pulse(0);
        tick(3);
        chk(32'({p15, menu, sview}), 32'h5);
        pulse(3);
        tick(2);
        chk(32'(menu), 32'h0);
        // standby with off-only action: off, never back on
        sbq <= 1'h1;
        tick(8);
        chk(32'(dc), 32'h0);
        sbq <= 1'h0;
        tick(8);
        chk(32'(dc), 32'h0);
        bus(1'h1, OFS_CTRL, 32'h345);
        pulse(0);
        sbq <= 1'h1;
        tick(8);
        chk(32'(dc), 32'h0);
        sbq <= 1'h0;
        tick(8);
        chk(32'(dc), 32'h1);
        // polarity swap glitches the standby level for a few cycles; on/off action restores the stage
        bus(1'h1, OFS_CTRL, 32'h365);
        inv <= 1'h1;
        tick(10);
        chk(32'(dc), 32'h1);
        sbq <= 1'h1;
        tick(8);
        chk(32'(dc), 32'h0);
        sbq <= 1'h0;
        tick(8);
        chk(32'(dc), 32'h1);
        bus(1'h1, OFS_IRQ_EN, 32'h10);
        bus(1'h1, OFS_CTRL, 32'h364);
        // local control still works under lockout, remote off does not
        pulse(0);
        pulse(4);
        tick(3);
        chk(32'({lonly, dc, irq}), 32'h7);
        pulse(1);
        pulse(2);
        tick(3);
        chk(32'({lonly, dc, irq}), 32'h5);
        // analog remote request is ignored as well while locked out
        ana <= 1'h1;
        tick(3);
        chk(32'(dc), 32'h0);
        ana <= 1'h0;
        bus(1'h0, OFS_IRQ_STAT, 32'h0);
        chk(q & 32'h10, 32'h10);
        bus(1'h1, OFS_IRQ_CLR, 32'h1F);
        tick(2);
        chk(32'(irq), 32'h0);
        bus(1'h1, OFS_IRQ_EN, 32'h0);
        pulse(2);
        tick(3);
        chk(32'(irq), 32'h0);
        bus(1'h1, OFS_CTRL, 32'h365);
        pulse(2);
        tick(3);
        chk(32'({lonly, dc}), 32'h1);
        pf <= 1'h1;
        tick(3);
        chk(32'(dc), 32'h0);
        pf <= 1'h0;
        // analog remote with remote allowed: stage follows the released standby pin
        ana <= 1'h1;
        tick(3);
        chk(32'(dc), 32'h1);
        ana <= 1'h0;
        bus(1'h1, OFS_CTRL, 32'h31B);
        tick(2);
        chk(32'({rmode, shr, spd, r10}), 32'h1D);
        bus(1'h1, OFS_CTRL, 32'h301);
        tick(2);
        chk(32'({rmode, shr, spd, r10}), 32'h0);
        // an empty second-alarm mask is refused, the rest of the word lands
        bus(1'h1, OFS_CTRL, 32'h001);
        bus(1'h0, OFS_CTRL, 32'h0);
        chk(q, 32'h201);
        bus(1'h0, 5'h14, 32'h0);
        chk(q, 32'h0);
        tally_and_finish();
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        tick(5000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : asr_router_tb
